// ===== logic/program_sequencer_interrupt.sv
// Our own choices: register access over APB and the address map.
`include "seq_int_defs.svh"

// Notes on behaviour
// - table pointer plus accumulator form the 7-bit in-page rom address
// - table fetch loads rom bits 9:8 into pointer bits 1:0, bit 2 zero
// - eight stack entries hold return addresses for call, int, table
// - pushing past eight wraps the pointer and overwrites entries
// - 3-bit depth pointer moves on push/pop, copyable to accumulator
// - interrupt entry saves pointer, carry, skip, acc, aux in context
// - context register written only on interrupt entry
// - skip flag decides skipping and survives an interrupt via context
// - counter advances by length, or loads targets on control transfer
// - page field above bit 6; address 127 rolls into next page
// - data pointer is group, file, digit; digit selects port bit
// - rom is 10-bit words in 128-word pages, 48 or 64 pages
// - interrupt vectors sit at the bottom of page 1, offsets 0 to 14
// - single-word call reaches page 2 from any page
// - 4-bit data words, single-bit mask available everywhere
// - interrupt needs request flag, its enable and global enable
// - global enable set by enable, cleared by disable and by entry
// - enable bit one means interrupt, zero means skip-testable
// - request flag cleared on entry or on a taken skip test
// - request flag stays set while disabled until cleared
// - lowest priority number first; vectors at 0,2,4.. in page 1
// - entry clears only the served source's request flag
// - enable acts only after the following instruction completes
// - entry follows one to two machine cycles after conditions
module program_sequencer_interrupt (
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    input  wire logic                 clkEn,
    input  wire seq_int_pkg::instr_t  instr,
    input  wire seq_int_pkg::core_t   coreState,
    input  wire logic [7:0]           srcEvent,
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic      [12:0]          programCounter,
    output logic                      mcEndOut,
    output logic                      entryBusy,
    output logic                      skipNext,
    output logic      [9:0]           dataAddr,
    output logic      [7:0]           portBitMask,
    output logic      [3:0]           ramBitMask,
    output logic                      accWrite,
    output logic      [3:0]           accWriteData,
    output logic                      restoreValid,
    output seq_int_pkg::core_t        restoreCore,
    output logic                      intTaken,
    output logic      [2:0]           intSource
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] oneHot8(input logic [2:0] sel);
        oneHot8 = 8'h01 << sel;
    endfunction : oneHot8

    function automatic logic [2:0] firstSet(input logic [7:0] vec);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (vec[i]) begin
                idx = 3'(i);
            end
        end
        firstSet = idx;
    endfunction : firstSet

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [1:0]              phase_q;
    logic                    mcEnd;
    seq_int_pkg::seq_state_t state_q;
    logic [12:0]             pc_q;
    logic [12:0]             pc_d;
    logic [12:0]             stackMem_q [8];
    logic [2:0]              sp_q;
    logic [2:0]              tptr_q;
    logic [9:0]              dp_q;
    logic                    skip_q;
    logic                    gie_q;
    logic                    eiArm_q;
    logic [7:0]              flags_q;
    logic [7:0]              enables_q;
    logic [2:0]              srcSel_q;
    seq_int_pkg::ctx_t       ctx_q;

    logic                    exec;
    logic                    executed;
    logic                    entryNow;
    logic                    push;
    logic                    pop;
    logic [12:0]             pushVal;
    logic [12:0]             pcInc;
    logic [12:0]             stackTop;
    logic [6:0]              tableOff;
    logic [7:0]              ready;
    logic                    takeNow;
    logic                    skipTaken;
    logic [7:0]              flagClr;
    logic                    apbDone;
    logic                    apbWrEn;

    // ------------------------------------------------------------------
    // machine cycle: three system clocks
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            phase_q <= 2'd0;
        end else if (clkEn) begin
            phase_q <= (phase_q == `MC_LAST) ? 2'd0 : phase_q + 2'd1;
        end
    end

    assign mcEnd    = clkEn && (phase_q == `MC_LAST);
    assign exec     = mcEnd && instr.valid && (state_q == seq_int_pkg::ST_RUN);
    // a skipped instruction only advances the counter
    assign executed = exec && !skip_q;
    assign entryNow = mcEnd && (state_q == seq_int_pkg::ST_ENTRY);

    // ------------------------------------------------------------------
    // next counter value and stack moves
    // ------------------------------------------------------------------
    assign pcInc    = pc_q + {11'h000, instr.len};
    assign stackTop = stackMem_q[sp_q - 3'd1];
    assign tableOff = {tptr_q, instr.acc};
    assign ready    = flags_q & enables_q;

    always_comb begin
        pc_d    = pc_q;
        push    = 1'b0;
        pop     = 1'b0;
        pushVal = pcInc;
        if (entryNow) begin
            push    = 1'b1;
            pushVal = pc_q;
            pc_d    = {`VECTOR_PAGE, 3'h0, srcSel_q, 1'b0};
        end else if (exec && skip_q) begin
            pc_d = pcInc;
        end else if (executed) begin
            unique case (instr.op)
                seq_int_pkg::OP_BRANCH: begin
                    pc_d = instr.target;
                end
                seq_int_pkg::OP_CALL: begin
                    push = 1'b1;
                    pc_d = instr.target;
                end
                seq_int_pkg::OP_PAGE2_CALL: begin
                    push = 1'b1;
                    pc_d = {`CALL_PAGE, instr.target[6:0]};
                end
                seq_int_pkg::OP_IND_BRANCH: begin
                    pc_d = {pc_q[12:7], tableOff};
                end
                seq_int_pkg::OP_IND_CALL: begin
                    push = 1'b1;
                    pc_d = {pc_q[12:7], tableOff};
                end
                seq_int_pkg::OP_RETURN,
                seq_int_pkg::OP_RETURN_INT,
                seq_int_pkg::OP_TABLE_END: begin
                    pop  = 1'b1;
                    pc_d = stackTop;
                end
                seq_int_pkg::OP_TABLE_START: begin
                    push = 1'b1;
                    pc_d = {instr.target[12:7], tableOff};
                end
                default: begin
                    pc_d = pcInc;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // program counter and return stack
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pc_q <= `RST_PC;
        end else if (clkEn) begin
            pc_q <= pc_d;
        end
    end

    // no overflow guard: a ninth push silently overwrites the oldest
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sp_q <= `RST_SP;
        end else if (clkEn) begin
            if (push) begin
                stackMem_q[sp_q] <= pushVal;
                sp_q             <= sp_q + 3'd1;
            end else if (pop) begin
                sp_q <= sp_q - 3'd1;
            end
        end
    end

    // ------------------------------------------------------------------
    // table pointer and data pointer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tptr_q <= `RST_TPTR;
        end else if (clkEn && executed) begin
            if (instr.op == seq_int_pkg::OP_LOAD_TPTR) begin
                tptr_q <= instr.imm[2:0];
            end else if (instr.op == seq_int_pkg::OP_TABLE_END) begin
                tptr_q <= {`TABLE_TOP_BIT, instr.romData[9:8]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dp_q <= `RST_DP;
        end else if (clkEn) begin
            if (executed && instr.op == seq_int_pkg::OP_RETURN_INT) begin
                dp_q <= ctx_q.dataPtr;
            end else if (executed && instr.op == seq_int_pkg::OP_LOAD_DP) begin
                dp_q <= instr.imm;
            end
        end
    end

    // ------------------------------------------------------------------
    // skip flag
    // ------------------------------------------------------------------
    assign skipTaken = executed && (instr.op == seq_int_pkg::OP_TEST_REQUEST)
                       && flags_q[instr.src] && !enables_q[instr.src];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            skip_q <= 1'b0;
        end else if (clkEn) begin
            if (entryNow) begin
                skip_q <= 1'b0;
            end else if (exec) begin
                if (!executed) begin
                    skip_q <= 1'b0;
                end else if (instr.op == seq_int_pkg::OP_SKIP_COND) begin
                    skip_q <= instr.skipCond;
                end else if (instr.op == seq_int_pkg::OP_TEST_REQUEST) begin
                    skip_q <= skipTaken;
                end else if (instr.op == seq_int_pkg::OP_RETURN_INT) begin
                    skip_q <= ctx_q.skip;
                end else begin
                    skip_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt context: one stage, written only on entry
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctx_q <= '0;
        end else if (clkEn && entryNow) begin
            ctx_q.dataPtr <= dp_q;
            ctx_q.skip    <= skip_q;
            ctx_q.core    <= coreState;
        end
    end

    // ------------------------------------------------------------------
    // global enable with one-instruction delay
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gie_q   <= 1'b0;
            eiArm_q <= 1'b0;
        end else if (clkEn) begin
            if (entryNow) begin
                gie_q   <= 1'b0;
                eiArm_q <= 1'b0;
            end else if (executed && instr.op == seq_int_pkg::OP_DISABLE_INT) begin
                gie_q   <= 1'b0;
                eiArm_q <= 1'b0;
            end else if (executed && instr.op == seq_int_pkg::OP_ENABLE_INT) begin
                eiArm_q <= 1'b1;
            end else if (exec && eiArm_q) begin
                gie_q   <= 1'b1;
                eiArm_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // request flags and per-source enables
    // ------------------------------------------------------------------
    always_comb begin
        flagClr = 8'h00;
        if (entryNow) begin
            flagClr = oneHot8(srcSel_q);
        end else if (skipTaken) begin
            flagClr = oneHot8(instr.src);
        end
    end

    // an event in the clearing cycle survives
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_q <= 8'h00;
        end else if (clkEn) begin
            flags_q <= (flags_q & ~flagClr) | srcEvent;
        end
    end

    assign apbDone = psel && penable && pready;
    assign apbWrEn = apbDone && pwrite && (paddr == `OFF_ENABLE);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enables_q <= `RST_ENABLES;
        end else if (clkEn) begin
            if (executed && instr.op == seq_int_pkg::OP_WRITE_ENABLE) begin
                if (instr.src[0]) begin
                    enables_q[7:4] <= instr.acc;
                end else begin
                    enables_q[3:0] <= instr.acc;
                end
            end else if (apbWrEn) begin
                enables_q <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // entry sequencing: decided at an instruction boundary
    // ------------------------------------------------------------------
    // a multi-cycle instruction delays the boundary by one machine cycle
    assign takeNow = exec && gie_q && (|ready) && !skipTaken
                     && !(executed && instr.op == seq_int_pkg::OP_DISABLE_INT);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q  <= seq_int_pkg::ST_RUN;
            srcSel_q <= 3'h0;
        end else if (clkEn) begin
            unique case (state_q)
                seq_int_pkg::ST_RUN: begin
                    if (takeNow) begin
                        state_q  <= seq_int_pkg::ST_ENTRY;
                        srcSel_q <= firstSet(ready);
                    end
                end
                seq_int_pkg::ST_ENTRY: begin
                    if (mcEnd) begin
                        state_q <= seq_int_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registered outputs toward the core
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            accWrite     <= 1'b0;
            accWriteData <= 4'h0;
            restoreValid <= 1'b0;
            restoreCore  <= '0;
            intTaken     <= 1'b0;
            intSource    <= 3'h0;
        end else if (clkEn) begin
            accWrite     <= 1'b0;
            restoreValid <= 1'b0;
            intTaken     <= entryNow;
            if (entryNow) begin
                intSource <= srcSel_q;
            end
            if (executed && instr.op == seq_int_pkg::OP_READ_DEPTH) begin
                accWrite     <= 1'b1;
                accWriteData <= {1'b0, sp_q};
            end else if (executed && instr.op == seq_int_pkg::OP_READ_ENABLE) begin
                accWrite     <= 1'b1;
                accWriteData <= instr.src[0] ? enables_q[7:4]
                                             : enables_q[3:0];
            end
            if (executed && instr.op == seq_int_pkg::OP_RETURN_INT) begin
                restoreValid <= 1'b1;
                restoreCore  <= ctx_q.core;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            programCounter <= `RST_PC;
            mcEndOut       <= 1'b0;
            entryBusy      <= 1'b0;
            skipNext       <= 1'b0;
            dataAddr       <= `RST_DP;
            portBitMask    <= 8'h00;
            ramBitMask     <= 4'h0;
        end else if (clkEn) begin
            programCounter <= pc_d;
            mcEndOut       <= (phase_q == 2'd1);
            entryBusy      <= (state_q == seq_int_pkg::ST_ENTRY) && !mcEnd
                              || takeNow;
            skipNext       <= skip_q;
            dataAddr       <= dp_q;
            portBitMask    <= oneHot8(dp_q[2:0]);
            if (executed) begin
                ramBitMask <= 4'(oneHot8({1'b0, instr.imm[1:0]}));
            end
        end
    end

    // ------------------------------------------------------------------
    // apb slave: zero wait states, errors on unmapped offsets
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            if (psel && !penable) begin
                pready  <= 1'b1;
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
                unique case (paddr)
                    `OFF_ENABLE: begin
                        prdata[7:0] <= enables_q;
                    end
                    `OFF_STATUS: begin
                        prdata[`ST_FLAGS_LSB +: 8] <= flags_q;
                        prdata[`ST_GIE_BIT]        <= gie_q;
                        prdata[`ST_SP_LSB +: 3]    <= sp_q;
                        prdata[`ST_SKIP_BIT]       <= skip_q;
                        prdata[`ST_ENTRY_BIT]      <= state_q;
                    end
                    `OFF_PROG_CNT: begin
                        prdata[12:0] <= pc_q;
                    end
                    `OFF_POINTERS: begin
                        prdata[`PTR_DP_LSB +: 10] <= dp_q;
                        prdata[`PTR_TP_LSB +: 3]  <= tptr_q;
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

endmodule : program_sequencer_interrupt

// ===== include/seq_int_defs.svh
`ifndef SEQ_INT_DEFS_SVH
`define SEQ_INT_DEFS_SVH

// ----------------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------------
`define OFF_ENABLE     8'h00
`define OFF_STATUS     8'h04
`define OFF_PROG_CNT   8'h08
`define OFF_POINTERS   8'h0c

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ST_FLAGS_LSB   0
`define ST_GIE_BIT     8
`define ST_SP_LSB      9
`define ST_SKIP_BIT    12
`define ST_ENTRY_BIT   13
`define PTR_DP_LSB     0
`define PTR_TP_LSB     16

// ----------------------------------------------------------------------
// reset values and fixed addresses
// ----------------------------------------------------------------------
`define RST_PC         13'h0000
`define RST_ENABLES    8'h00
`define RST_SP         3'h0
`define RST_TPTR       3'h0
`define RST_DP         10'h000
`define VECTOR_PAGE    6'h01
`define CALL_PAGE      6'h02
`define TABLE_TOP_BIT  1'b0

// ----------------------------------------------------------------------
// timing: system clock cycles per machine cycle
// ----------------------------------------------------------------------
`define MC_DIV         2'd3
`define MC_LAST        2'd2

`endif

// ===== include/seq_int_pkg.sv
package seq_int_pkg;

    // ------------------------------------------------------------------
    // instruction classes issued by the decoder
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_ADVANCE      = 5'h00,
        OP_BRANCH       = 5'h01,
        OP_CALL         = 5'h02,
        OP_PAGE2_CALL   = 5'h03,
        OP_IND_BRANCH   = 5'h04,
        OP_IND_CALL     = 5'h05,
        OP_RETURN       = 5'h06,
        OP_RETURN_INT   = 5'h07,
        OP_TABLE_START  = 5'h08,
        OP_TABLE_END    = 5'h09,
        OP_ENABLE_INT   = 5'h0a,
        OP_DISABLE_INT  = 5'h0b,
        OP_READ_DEPTH   = 5'h0c,
        OP_WRITE_ENABLE = 5'h0d,
        OP_READ_ENABLE  = 5'h0e,
        OP_TEST_REQUEST = 5'h0f,
        OP_SKIP_COND    = 5'h10,
        OP_LOAD_DP      = 5'h11,
        OP_LOAD_TPTR    = 5'h12
    } op_t;

    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_ENTRY = 1'b1
    } seq_state_t;

    typedef struct packed {
        logic        valid;
        op_t         op;
        logic [1:0]  len;
        logic [12:0] target;
        logic [2:0]  src;
        logic        skipCond;
        logic [9:0]  imm;
        logic [3:0]  acc;
        logic [9:0]  romData;
    } instr_t;

    typedef struct packed {
        logic       carry;
        logic [3:0] acc;
        logic [3:0] aux;
    } core_t;

    typedef struct packed {
        logic [9:0] dataPtr;
        logic       skip;
        core_t      core;
    } ctx_t;

endpackage : seq_int_pkg

// ===== tb/seq_int_chk.sv
module seq_int_chk (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [12:0] programCounter,
    input wire logic        mcEndOut,
    input wire logic        entryBusy,
    input wire logic        accWrite,
    input wire logic        intTaken,
    input wire logic [2:0]  intSource
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
        else $error("late answer");
    AST_UNMAPPED: assert property (penable && paddr > 8'h0c |-> pslverr)
        else $error("no refusal");
    AST_VECTOR: assert property (intTaken |->
        programCounter == {6'h01, 3'h0, intSource, 1'h0}) else $error("vec");
    AST_LATENCY: assert property ($rose(entryBusy) |-> ##[1:5] intTaken)
        else $error("slow entry");
    AST_ENTRY_END: assert property (entryBusy && mcEndOut |=> !entryBusy)
        else $error("entry stuck");
    AST_PC_AT_END: assert property ($changed(programCounter) |->
        $past(mcEndOut)) else $error("pc off cycle end");
    AST_MC_THREE: assert property (mcEndOut |=>
        !mcEndOut [*2] ##1 mcEndOut) else $error("cycle length");
    AST_INT_PULSE: assert property (intTaken |=> !intTaken)
        else $error("long pulse");
    AST_ACC_PULSE: assert property (accWrite |=> !accWrite)
        else $error("long acc pulse");
    COV_INT: cover property (intTaken);
    COV_ERR: cover property (pslverr);
    COV_ACC: cover property (accWrite);
endmodule : seq_int_chk

bind program_sequencer_interrupt seq_int_chk u_chk (.clk_sys, .sys_rst,
    .psel, .penable, .paddr, .pready, .pslverr, .programCounter, .mcEndOut,
    .entryBusy, .accWrite, .intTaken, .intSource);

// ===== tb/decoder_model.sv
module decoder_model (
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  wire logic                mcEndOut,
    input  wire logic                entryBusy,
    input  wire seq_int_pkg::instr_t nextInstr,
    output seq_int_pkg::instr_t      instr,
    output logic                     consumed
);
    timeunit 1ns;
    timeprecision 1ps;
    seq_int_pkg::instr_t held_q;
    // valid is hidden during entry so nothing slips in
    assign instr = entryBusy ? '0 : held_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            held_q   <= '0;
            consumed <= 1'h0;
        end else begin
            consumed <= mcEndOut && !entryBusy && held_q.valid;
            if (mcEndOut && !entryBusy) begin
                held_q <= nextInstr;
            end
        end
    end
endmodule : decoder_model

// ===== tb/program_sequencer_interrupt_tb_top.sv
`include "seq_int_defs.svh"

module program_sequencer_interrupt_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk_sys = 1'h0;
    logic                sys_rst = 1'h1;
    logic                psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]          paddr = 8'h00, srcEvent = 8'h00;
    logic [31:0]         pwdata = 32'h0, prdata, r, seed;
    logic                pready, pslverr, e, mcEndOut, entryBusy;
    logic                accWrite, restoreValid, intTaken, consumed;
    logic [12:0]         programCounter;
    logic [3:0]          accWriteData, gotAcc;
    logic [2:0]          intSource, gotSrc;
    seq_int_pkg::instr_t instr, nextI = '0;
    seq_int_pkg::core_t  coreState, restoreCore, gotCore;
    int                  failures = 0, samples_checked = 0;

    program_sequencer_interrupt u_dut (.clk_sys, .sys_rst, .clkEn(1'h1),
        .instr, .coreState, .srcEvent, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .programCounter, .mcEndOut,
        .entryBusy, .skipNext(), .dataAddr(), .portBitMask(),
        .ramBitMask(), .accWrite, .accWriteData, .restoreValid,
        .restoreCore, .intTaken, .intSource);
    decoder_model u_dec (.clk_sys, .sys_rst, .mcEndOut, .entryBusy,
        .nextInstr(nextI), .instr, .consumed);

    initial forever #12.5 clk_sys = ~clk_sys;
    // pulses last one clock, so they are caught as they pass
    always @(posedge clk_sys) begin
        if (intTaken === 1'h1) gotSrc <= intSource;
        if (accWrite === 1'h1) gotAcc <= accWriteData;
        if (restoreValid === 1'h1) gotCore <= restoreCore;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'h1) begin
            failures++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1 && ++n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic run(input seq_int_pkg::op_t op, input logic [12:0] t);
        int n = 0;
        nextI <= '{valid: 1'h1, op: op, len: 2'h1, target: t, default: '0};
        do @(posedge clk_sys); while (instr.valid !== 1'h1 && ++n < 30);
        nextI <= '0;
        do @(posedge clk_sys); while (consumed !== 1'h1 && ++n < 60);
    endtask : run

    initial begin
        seed = xs(32'h4a2f);
        coreState = seed[8:0];
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'h0;
        apb(1'h0, `OFF_STATUS, 32'h0);
        chk(r[13:0] === 14'h0000, "status at reset");
        seed = xs(seed);
        apb(1'h1, `OFF_ENABLE, seed);
        apb(1'h0, `OFF_ENABLE, 32'h0);
        chk(r[7:0] === seed[7:0], "enable readback");
        apb(1'h1, 8'h10, seed);
        chk(e === 1'h1 && r === 32'h0, "unmapped");
        run(seq_int_pkg::OP_BRANCH, 13'h007f);
        run(seq_int_pkg::OP_ADVANCE, 13'h0);
        chk(programCounter === 13'h0080, "page roll");
        apb(1'h1, `OFF_ENABLE, 32'h6);
        srcEvent <= 8'h07;
        @(posedge clk_sys);
        srcEvent <= 8'h00;
        run(seq_int_pkg::OP_ENABLE_INT, 13'h0);
        for (int i = 0; i < 2; i++) run(seq_int_pkg::OP_ADVANCE, 13'h0);
        repeat (20) @(posedge clk_sys);
        chk(gotSrc === 3'h1, "served source");
        apb(1'h0, `OFF_STATUS, 32'h0);
        chk(r[13:0] === 14'h0205, "flags after entry");
        run(seq_int_pkg::OP_READ_DEPTH, 13'h0);
        repeat (2) @(posedge clk_sys);
        chk(gotAcc === 4'h1, "depth after entry");
        run(seq_int_pkg::OP_RETURN_INT, 13'h0);
        repeat (2) @(posedge clk_sys);
        chk(gotCore === coreState, "context restore");
        for (int i = 0; i < 9; i++) run(seq_int_pkg::OP_CALL, 13'h0100);
        run(seq_int_pkg::OP_PAGE2_CALL, 13'h1f05);
        chk(programCounter === 13'h0105, "page 2 call");
        run(seq_int_pkg::OP_READ_DEPTH, 13'h0);
        repeat (2) @(posedge clk_sys);
        chk(gotAcc === 4'h2, "stack wrap");
        tally_and_finish();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        failures++;
        tally_and_finish();
    end
endmodule : program_sequencer_interrupt_tb_top
